// [design/tvw_wdog.sv]
// Package of trap and watchdog constants plus the watchdog counter module
//
// Behaviour
// - Hardware, software and watchdog resets vector to zero, trap zero, no flag.
// - NMI, stack overflow, underflow vector to 08h, 10h, 18h; own flags.
// - Five class B faults set own flags, share vector 28h, trap 0Ah.
// - Software trap takes 00h-7Fh, vectors to four times number, current priority.
// - Every class A and class B trap sets its own bit in the trap flag register; resets set none.
// - Hardware traps preempt unless same or higher class trap serviced; block standard interrupts.
// - Watchdog counts immediately after every reset.
// - Disable works only before end-of-init; later disable requests ignored.
// - Watchdog overflow causes internal reset and drives reset output low.
// - 16-bit up counter clocked at system clock divided by 2 or 128.
// - Service loads counter high byte from reload value.
// - Reset settings give 5.24 ms overflow interval at 25 MHz.
// - End-of-init command raises the reset output level.

`timescale 1ns/100ps
package tvw_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_TRAP_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h04;
    localparam logic [7:0] ADDR_WDT_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_WDT_COUNT  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;
    // Trap flag bit positions
    localparam int BIT_NMI          = 0;
    localparam int BIT_STACK_OVER   = 1;
    localparam int BIT_STACK_UNDER  = 2;
    localparam int BIT_UNDEF_OPCODE = 3;
    localparam int BIT_PROT_FAULT   = 4;
    localparam int BIT_WORD_OPERAND = 5;
    localparam int BIT_INSTR_ACCESS = 6;
    localparam int BIT_EXT_BUS      = 7;
    localparam int NUM_TRAPS   = 8;
    localparam int NUM_CLASS_A = 3;
    // Watchdog control field positions
    localparam int WDT_RELOAD_LSB = 0;
    localparam int WDT_PRESC_BIT  = 8;
    // Reset values
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic       RST_PRESC  = 1'b0;
    localparam logic [7:0] RST_MASK   = 8'h00;
    // ----------------------------------------------------------------
    // Trap numbers and priorities
    // ----------------------------------------------------------------
    localparam logic [6:0] TN_RESET   = 7'h00;
    localparam logic [6:0] TN_NMI     = 7'h02;
    localparam logic [6:0] TN_STACK_OVER  = 7'h04;
    localparam logic [6:0] TN_STACK_UNDER = 7'h06;
    localparam logic [6:0] TN_CLASS_B = 7'h0a;
    localparam logic [6:0] TN_RSV_LO  = 7'h0b;
    localparam logic [6:0] TN_RSV_HI  = 7'h0f;
    localparam logic [3:0] PRIO_HW    = 4'hf;
    // ----------------------------------------------------------------
    // Watchdog timing
    // ----------------------------------------------------------------
    localparam int PRESC_LO  = 2;
    localparam int PRESC_HI  = 128;
    localparam int WDT_WIDTH = 16;
    // Reset settings: 65536 ticks at /2 -> 131072 cycles, 5.24 ms at 25 MHz
    localparam int WDT_DEFAULT_CYCLES = (1 << WDT_WIDTH) * PRESC_LO;
    // Shortest 256 ticks at /2, longest 65536 ticks at /128
    localparam int WDT_MIN_CYCLES = 256 * PRESC_LO;
    localparam int WDT_MAX_CYCLES = (1 << WDT_WIDTH) * PRESC_HI;

    typedef enum logic [1:0] {
        RANK_NONE = 2'b00,
        RANK_B    = 2'b01,
        RANK_A    = 2'b10
    } tvw_rank_type;

    // Vector location is four times the trap number
    function automatic logic [23:0] tvw_vector(input logic [6:0] num);
        return {15'h0000, num, 2'b00};
    endfunction
endpackage

// Watchdog: prescaled 16-bit up counter with disable window
module tvw_wdog #(
    parameter int WIDTH = tvw_pkg::WDT_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             restart,
    input  wire logic             service,
    input  wire logic             disable_req,
    input  wire logic             end_init,
    input  wire logic [7:0]       reload,
    input  wire logic             presc_sel,
    output logic [WIDTH-1:0]      count,
    output logic                  enabled,
    output logic                  init_done,
    output logic                  overflow
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic [6:0]       pre;
        logic             en;
        logic             done;
        logic             ovf;
    } tvw_wdog_type;

    tvw_wdog_type st;
    tvw_wdog_type next_st;
    logic         tick;

    // Divide by 2 or 128
    assign tick = presc_sel ? (st.pre == 7'h7f) : st.pre[0];

    always_comb begin
        next_st     = st;
        next_st.ovf = 1'b0;
        next_st.pre = st.en ? st.pre + 7'h01 : 7'h00;
        if (restart) begin
            // Internal reset: counting restarts at once, window reopens
            next_st = '{cnt: '0, pre: 7'h00, en: 1'b1, done: 1'b0, ovf: 1'b0};
        end else begin
            if (st.en && tick) begin
                next_st.cnt = st.cnt + 1'b1;
                next_st.ovf = &st.cnt;
            end
            if (service) begin
                next_st.cnt = {reload, 8'h00};
                next_st.pre = 7'h00;
            end
            if (disable_req && !st.done) begin
                next_st.en = 1'b0;
            end
            if (end_init) begin
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '{cnt: '0, pre: 7'h00, en: 1'b1, done: 1'b0, ovf: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign count     = st.cnt;
    assign enabled   = st.en;
    assign init_done = st.done;
    assign overflow  = st.ovf;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_run_after_reset: assert property (restart |=> enabled && count == '0 && !init_done)
        else $error("watchdog not running after internal reset");
    a_disable_locked: assert property (init_done && enabled && !restart |=> enabled)
        else $error("watchdog disabled after end of init");
    a_service_reload: assert property (service && !restart |=> count == {$past(reload), 8'h00})
        else $error("service did not load reload byte");
    a_div2_rate: assert property (enabled && !presc_sel && !service && !restart
        && !disable_req ##1 !presc_sel && !service && !restart && !disable_req
        |-> count == $past(count, 1) + 1'b1 || count == $past(count, 1))
        else $error("watchdog count jumped");
    a_ovf_wrap: assert property (overflow |-> count == '0 || $past(service) || $past(restart))
        else $error("overflow without wrap");
endmodule

// [design/tvw_top.sv]
// Trap vector selection, trap flags and watchdog reset control
`timescale 1ns/100ps
module tvw_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // Trap sources, one-cycle pulses
    input  wire logic        nmi_req,
    input  wire logic        stack_over_req,
    input  wire logic        stack_under_req,
    input  wire logic        undef_opcode_req,
    input  wire logic        prot_fault_req,
    input  wire logic        word_operand_req,
    input  wire logic        instr_access_req,
    input  wire logic        ext_bus_req,
    // CPU commands, one-cycle pulses
    input  wire logic        sw_trap_req,
    input  wire logic [6:0]  sw_trap_num,
    input  wire logic [3:0]  cpu_prio,
    input  wire logic        trap_return,
    input  wire logic        watchdog_service_command,
    input  wire logic        watchdog_disable_command,
    input  wire logic        end_of_init_command,
    input  wire logic        software_reset_command,
    // Vector output
    output logic             vec_valid,
    output logic [23:0]      vec_addr,
    output logic [6:0]       vec_num,
    output logic [3:0]       vec_prio,
    output logic             hw_trap_busy,
    output logic             sys_reset_req,
    output logic             reset_output_pin_n,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]            flags;
        logic [7:0]            mask;
        logic [7:0]            pend;
        logic                  sw_pend;
        logic [6:0]            sw_num;
        logic [3:0]            sw_prio;
        logic                  rst_pend;
        tvw_pkg::tvw_rank_type rank;
        tvw_pkg::tvw_rank_type saved;
        logic                  vld;
        logic [23:0]           addr;
        logic [6:0]            num;
        logic [3:0]            prio;
        logic [7:0]            reload;
        logic                  presc;
        logic                  sys_rst;
        logic                  rst_out_n;
        logic [15:0]           rdata;
    } tvw_state_type;

    tvw_state_type st;
    tvw_state_type next_st;
    logic [7:0]    trap_in;
    logic          restart;
    logic [15:0]   wdt_count;
    logic          wdt_enabled;
    logic          init_done;
    logic          wdt_ovf;

    assign trap_in = {ext_bus_req, instr_access_req, word_operand_req, prot_fault_req,
                      undef_opcode_req, stack_under_req, stack_over_req, nmi_req};
    // Both reset causes take the same internal path
    assign restart = software_reset_command | wdt_ovf;

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    tvw_wdog #(
        .WIDTH (tvw_pkg::WDT_WIDTH)
    ) u_wdog (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .restart     (restart),
        .service     (watchdog_service_command),
        .disable_req (watchdog_disable_command),
        .end_init    (end_of_init_command),
        .reload      (st.reload),
        .presc_sel   (st.presc),
        .count       (wdt_count),
        .enabled     (wdt_enabled),
        .init_done   (init_done),
        .overflow    (wdt_ovf)
    );

    // Lowest bit wins among class A sources
    function automatic logic [6:0] class_a_num(input logic [2:0] p);
        if (p[tvw_pkg::BIT_NMI]) begin
            return tvw_pkg::TN_NMI;
        end else if (p[tvw_pkg::BIT_STACK_OVER]) begin
            return tvw_pkg::TN_STACK_OVER;
        end else begin
            return tvw_pkg::TN_STACK_UNDER;
        end
    endfunction

    function automatic logic [2:0] class_a_pick(input logic [2:0] p);
        return p & (~p + 3'h1);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] clr;
        clr           = 8'h00;
        next_st       = st;
        next_st.vld   = 1'b0;
        next_st.rdata = 16'h0000;
        next_st.sys_rst = restart;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                tvw_pkg::ADDR_TRAP_FLAGS: clr = reg_wdata[7:0];
                tvw_pkg::ADDR_IRQ_MASK:   next_st.mask = reg_wdata[7:0];
                tvw_pkg::ADDR_WDT_CTRL: begin
                    next_st.reload = reg_wdata[tvw_pkg::WDT_RELOAD_LSB +: 8];
                    next_st.presc  = reg_wdata[tvw_pkg::WDT_PRESC_BIT];
                end
                default: ;
            endcase
        end
        // Set wins over a write-one-to-clear in the same cycle
        next_st.flags = (st.flags & ~clr) | trap_in;
        next_st.pend  = st.pend | trap_in;

        if (reg_rd) begin
            case (reg_addr)
                tvw_pkg::ADDR_TRAP_FLAGS: next_st.rdata = {8'h00, st.flags};
                tvw_pkg::ADDR_IRQ_MASK:   next_st.rdata = {8'h00, st.mask};
                tvw_pkg::ADDR_WDT_CTRL:   next_st.rdata = {7'h00, st.presc, st.reload};
                tvw_pkg::ADDR_WDT_COUNT:  next_st.rdata = wdt_count;
                tvw_pkg::ADDR_STATUS:     next_st.rdata = {12'h000, st.rank,
                                                           wdt_enabled, init_done};
                default:                  next_st.rdata = 16'h0000;
            endcase
        end

        if (sw_trap_req) begin
            next_st.sw_pend = 1'b1;
            next_st.sw_num  = sw_trap_num;
            next_st.sw_prio = cpu_prio;
        end

        if (trap_return) begin
            next_st.rank  = st.saved;
            next_st.saved = tvw_pkg::RANK_NONE;
        end

        // Dispatch, highest class first; only pending state is looked at
        if (st.rst_pend) begin
            next_st.rst_pend = 1'b0;
            next_st.vld      = 1'b1;
            next_st.num      = tvw_pkg::TN_RESET;
            next_st.addr     = tvw_pkg::tvw_vector(tvw_pkg::TN_RESET);
            next_st.prio     = tvw_pkg::PRIO_HW;
        end else if ((|st.pend[2:0]) && st.rank != tvw_pkg::RANK_A) begin
            next_st.pend[2:0] = st.pend[2:0] & ~class_a_pick(st.pend[2:0]);
            next_st.vld   = 1'b1;
            next_st.num   = class_a_num(st.pend[2:0]);
            next_st.addr  = tvw_pkg::tvw_vector(class_a_num(st.pend[2:0]));
            next_st.prio  = tvw_pkg::PRIO_HW;
            next_st.rank  = tvw_pkg::RANK_A;
            next_st.saved = st.rank;
        end else if ((|st.pend[7:3]) && st.rank == tvw_pkg::RANK_NONE) begin
            // One shared entry serves all five faults; the flags tell them apart
            next_st.pend[7:3] = 5'h00;
            next_st.vld  = 1'b1;
            next_st.num  = tvw_pkg::TN_CLASS_B;
            next_st.addr = tvw_pkg::tvw_vector(tvw_pkg::TN_CLASS_B);
            next_st.prio = tvw_pkg::PRIO_HW;
            next_st.rank = tvw_pkg::RANK_B;
        end else if (st.sw_pend && st.rank == tvw_pkg::RANK_NONE) begin
            next_st.sw_pend = 1'b0;
            next_st.vld  = 1'b1;
            next_st.num  = st.sw_num;
            next_st.addr = tvw_pkg::tvw_vector(st.sw_num);
            next_st.prio = st.sw_prio;
        end

        // Reset output goes high only once initialisation is declared over
        if (end_of_init_command && !init_done) begin
            next_st.rst_out_n = 1'b1;
        end

        // Internal reset discards pending work; flags stay for diagnosis
        if (restart) begin
            next_st.rst_pend  = 1'b1;
            next_st.pend      = 8'h00;
            next_st.sw_pend   = 1'b0;
            next_st.rank      = tvw_pkg::RANK_NONE;
            next_st.saved     = tvw_pkg::RANK_NONE;
            next_st.reload    = tvw_pkg::RST_RELOAD;
            next_st.presc     = tvw_pkg::RST_PRESC;
            next_st.rst_out_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.mask     <= tvw_pkg::RST_MASK;
            st.rst_pend <= 1'b1;
            st.reload   <= tvw_pkg::RST_RELOAD;
            st.presc    <= tvw_pkg::RST_PRESC;
            st.rank     <= tvw_pkg::RANK_NONE;
            st.saved    <= tvw_pkg::RANK_NONE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata          = st.rdata;
    assign vec_valid          = st.vld;
    assign vec_addr           = st.addr;
    assign vec_num            = st.num;
    assign vec_prio           = st.prio;
    // Standard and event-controller interrupts hold off while high
    assign hw_trap_busy       = (st.rank != tvw_pkg::RANK_NONE);
    assign sys_reset_req      = st.sys_rst;
    assign reset_output_pin_n = st.rst_out_n;
    assign irq                = |(st.flags & st.mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = !st.rst_pend && st.pend == 8'h00 && !st.sw_pend && !restart
                   && st.rank == tvw_pkg::RANK_NONE && !trap_return;

    a_reset_vector: assert property (software_reset_command |-> ##2 vec_valid
        && vec_addr == 24'h000000 && vec_num == 7'h00)
        else $error("reset did not vector to zero");
    a_reset_no_flag: assert property (software_reset_command && trap_in == 8'h00 && !reg_wr
        |=> st.flags == $past(st.flags))
        else $error("reset changed trap flags");
    a_nmi_vector: assert property (quiet && nmi_req |-> ##2 vec_valid
        && vec_addr == 24'h000008 && vec_num == 7'h02)
        else $error("nmi vector wrong");
    a_class_b_vector: assert property (quiet && trap_in[2:0] == 3'h0 && |trap_in[7:3]
        |-> ##2 vec_valid && vec_addr == 24'h000028 && vec_num == 7'h0a)
        else $error("class b vector wrong");
    a_sw_trap: assert property (quiet && sw_trap_req && trap_in == 8'h00 |-> ##2 vec_valid
        && vec_num == $past(sw_trap_num, 2) && vec_prio == $past(cpu_prio, 2)
        && vec_addr == {15'h0000, $past(sw_trap_num, 2), 2'b00})
        else $error("software trap vector wrong");
    a_flag_record: assert property (trap_in != 8'h00 |=> (st.flags & $past(trap_in))
        == $past(trap_in))
        else $error("trap flag not set");
    a_no_nesting: assert property (st.rank == tvw_pkg::RANK_A && !trap_return
        |=> !(vec_valid && vec_num == tvw_pkg::TN_CLASS_B))
        else $error("class b entered during class a service");
    a_reset_output_pin_low: assert property (wdt_ovf |=> !reset_output_pin_n && sys_reset_req)
        else $error("overflow did not reset");
    a_end_init_level: assert property (end_of_init_command && !init_done && !restart
        |=> reset_output_pin_n)
        else $error("end of init not signalled");
    // Software traps may legally use any number, so only hardware entries are held to this
    a_reserved: assert property (vec_valid && hw_trap_busy
        |-> !(vec_num inside {[7'h0b:7'h0f]}) && !(vec_addr inside {[24'h2c:24'h3c]}))
        else $error("reserved vector used by hardware trap");

    c_nmi: cover property (vec_valid && vec_num == tvw_pkg::TN_NMI);
    c_class_b: cover property (vec_valid && vec_num == tvw_pkg::TN_CLASS_B);
    c_sw_trap: cover property (vec_valid && vec_prio != tvw_pkg::PRIO_HW);
    c_wdt_reset: cover property (wdt_ovf ##2 vec_valid);
    c_nested: cover property (st.rank == tvw_pkg::RANK_A && st.saved == tvw_pkg::RANK_B);
endmodule

// [dv/tvw_cpu_model.sv]
// CPU-side partner: ends hardware trap service and watches the reset output
`timescale 1ns/100ps
module tvw_cpu_model #(
    parameter int RET_DELAY = 4
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic vec_valid,
    input  wire logic hw_trap_busy,
    input  wire logic reset_output_pin_n,
    output logic      trap_return,
    output int        ext_resets
);
    int   cnt;
    logic pin_q;

    // Fixed handler length; one return per class A or B vector, and one more for a resumed outer service
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt         <= 0;
            trap_return <= 1'b0;
            pin_q       <= 1'b0;
            ext_resets  <= 0;
        end else begin
            if (vec_valid && hw_trap_busy) begin
                cnt <= RET_DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end else if (hw_trap_busy && !trap_return) begin
                cnt <= RET_DELAY;
            end
            trap_return <= (cnt == 1);
            pin_q       <= reset_output_pin_n;
            if (pin_q && !reset_output_pin_n) begin
                ext_resets <= ext_resets + 1;
            end
        end
    end
endmodule

// [dv/tvw_top_tb_top.sv]
// Self-checking bench for trap vectors, trap flags and the watchdog
`timescale 1ns/100ps
module tvw_top_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [13:0] ev = 14'h0000;
    logic [6:0]  sw_num = 7'h00;
    logic [3:0]  cpu_prio = 4'h3;
    logic [15:0] reg_rdata;
    logic [15:0] rd;
    logic [23:0] vec_addr;
    logic [6:0]  vec_num;
    logic [3:0]  vec_prio;
    logic        vec_valid, hw_trap_busy, sys_reset_req, pin_n, irq, trap_return;
    int          ext_resets;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc;

    tvw_top uut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nmi_req(ev[0]), .stack_over_req(ev[1]), .stack_under_req(ev[2]),
        .undef_opcode_req(ev[3]), .prot_fault_req(ev[4]), .word_operand_req(ev[5]),
        .instr_access_req(ev[6]), .ext_bus_req(ev[7]), .sw_trap_req(ev[8]),
        .sw_trap_num(sw_num), .cpu_prio(cpu_prio), .trap_return(trap_return),
        .watchdog_service_command(ev[10]), .watchdog_disable_command(ev[11]),
        .end_of_init_command(ev[12]), .software_reset_command(ev[13]),
        .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_num(vec_num), .vec_prio(vec_prio),
        .hw_trap_busy(hw_trap_busy), .sys_reset_req(sys_reset_req),
        .reset_output_pin_n(pin_n), .irq(irq)
    );
    tvw_cpu_model #(.RET_DELAY(4)) cpu (.clk_sys(clk_sys), .rst(rst), .vec_valid(vec_valid),
        .hw_trap_busy(hw_trap_busy), .reset_output_pin_n(pin_n), .trap_return(trap_return),
        .ext_resets(ext_resets));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Index of ev equals the trap flag bit for the eight hardware sources
    task automatic pulse(input int i);
        @(posedge clk_sys);
        ev[i] <= 1'b1;
        @(posedge clk_sys);
        ev[i] <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wt(input logic rstw, input int lim);
        cyc = 0;
        while ((rstw ? sys_reset_req : vec_valid) !== 1'b1 && cyc < lim) begin
            @(posedge clk_sys);
            #1 cyc++;
        end
    endtask
    task automatic vec(input logic [23:0] a, input logic [6:0] n, input logic [3:0] p);
        wt(0, 40);
        chk({vec_valid, vec_addr}, {1'b1, a});
        chk({vec_num, vec_prio}, {n, p});
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1 chk({vec_valid, vec_addr, vec_num}, 0 | 32'h1000000 << 7);
        chk(pin_n, 0);
        pulse(12);
        @(posedge clk_sys);
        #1 chk(pin_n, 1);
        pulse(11);
        rdreg(tvw_pkg::ADDR_STATUS, rd);
        chk(rd[1:0], 2'b11);
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            vec(i < 3 ? 24'(8 * (i + 1)) : 24'h28, i < 3 ? 7'(2 * i + 2) : 7'h0a, 4'hf);
            chk(hw_trap_busy, 1);
            rdreg(tvw_pkg::ADDR_TRAP_FLAGS, rd);
            chk(rd, 16'((1 << (i + 1)) - 1));
            repeat (8) @(posedge clk_sys);
        end
        // Class A preempts a running class B service, then both return in turn
        pulse(3);
        vec(24'h000028, 7'h0a, 4'hf);
        pulse(0);
        vec(24'h000008, 7'h02, 4'hf);
        rdreg(tvw_pkg::ADDR_STATUS, rd);
        chk(rd[3:2], 2'b10);
        repeat (16) @(posedge clk_sys);
        #1 chk(hw_trap_busy, 0);
        #1 chk(irq, 0);
        wr(tvw_pkg::ADDR_IRQ_MASK, 16'h0001);
        #1 chk(irq, 1);
        wr(tvw_pkg::ADDR_TRAP_FLAGS, 16'h0001);
        #1 chk(irq, 0);
        rdreg(tvw_pkg::ADDR_TRAP_FLAGS, rd);
        chk(rd, 16'h00fe);
        rdreg(8'h40, rd);
        chk(rd, 0);
        sw_num <= 7'h7f;
        pulse(8);
        vec(24'h0001fc, 7'h7f, 4'h3);
        wr(tvw_pkg::ADDR_WDT_CTRL, 16'h00ff);
        pulse(10);
        rdreg(tvw_pkg::ADDR_WDT_COUNT, rd);
        chk(rd[15:8], 8'hff);
        wt(1, 600);
        chk(cyc > 500 && cyc < 520, 1);
        chk(pin_n, 0);
        vec(24'h0, 7'h00, 4'hf);
        chk(ext_resets, 1);
        rdreg(tvw_pkg::ADDR_STATUS, rd);
        chk(rd[1:0], 2'b10);
        pulse(11);
        rdreg(tvw_pkg::ADDR_STATUS, rd);
        chk(rd[1], 0);
        pulse(13);
        #1 chk(sys_reset_req, 1);
        vec(24'h0, 7'h00, 4'hf);
        rdreg(tvw_pkg::ADDR_STATUS, rd);
        chk(rd[1], 1);
        wr(tvw_pkg::ADDR_WDT_CTRL, 16'h01ff);
        pulse(10);
        wt(1, 40000);
        chk(cyc > 32760 && cyc < 32780, 1);
        end_of_test();
    end

    // Whole run needs about 35000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        end_of_test();
    end
endmodule
